// >>> rtl/aof_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - DDR mode drives eleven bits per channel plus one shared forwarded clock.
// - Each DDR pair but the top one carries two successive bits per sample period, one per half.
// - Odd bits go out with forwarded clock high, even bits with it low.
// - Output current selection resets to 3.5 mA; 2.5, 4.5, 1.75 mA selectable.
// - A current double bit doubles data and clock buffer current.
// - Three termination legs enable independently, eight combinations.
// - Data pin and clock pin drive strength are raised independently.
// - Code format twos complement or offset binary, by register or select pin.
// - Positive overdrive gives 0x7FF offset binary, 0x3FF twos complement.
// - Negative overdrive gives 0x000 offset binary, 0x400 twos complement.
// - Multiplexed output only with single-ended parallel interface, never DDR.
// - Multiplexed mode interleaves both channels on bus B; bus A floats.
// - Multiplexed mode entered by power-state field or three mode pins.
// - Default pipeline delivers each sample 14 sample periods later.
// - Low-latency mode cuts the pipeline delay to 10 sample periods.
// - Low-latency mode bypasses the offset trim; output format and overdrive codes still apply.
// - Enabled offset loop estimates and subtracts each channel offset every sample.
// - Time-constant field selects span 2^27,2^26,2^25,2^24,2^28,2^29,2^27,2^27.
// - Freeze stops estimate updates while the last estimate stays subtracted.
// - Offset correction is off after reset until software enables it.
// - Power state 111 or all mode pins high selects multiplexed mode.
// - Parallel or DDR interface chosen by register bit or select pin.
//////////////////////////////////////////////////////////////////////////////
package aof_pkg;
    localparam int DATA_W = 11;
    localparam int PAIR_N = 6;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DRIVE = 8'h04;
    localparam logic [7:0] OFF_EST_A = 8'h08;
    localparam logic [7:0] OFF_EST_B = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    // Control register fields
    localparam int CTL_DDR = 0;
    localparam int CTL_TWOS = 1;
    localparam int CTL_LOWLAT = 2;
    localparam int CTL_PINS = 3;
    localparam int CTL_PS_LSB = 4;
    localparam int CTL_TRIM_EN = 8;
    localparam int CTL_FREEZE = 9;
    localparam int CTL_TC_LSB = 12;
    // Drive register fields
    localparam int DRV_CUR_LSB = 0;
    localparam int DRV_DOUBLE = 2;
    localparam int DRV_TERM_LSB = 3;
    localparam int DRV_DATA_STR = 6;
    localparam int DRV_CLK_STR = 7;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [7:0] DRIVE_RESET = 8'h00;
    localparam logic [1:0] CUR_3P5MA = 2'h0;
    localparam logic [1:0] CUR_2P5MA = 2'h1;
    localparam logic [1:0] CUR_4P5MA = 2'h2;
    localparam logic [1:0] CUR_1P75MA = 2'h3;
    localparam logic [2:0] PS_MUX = 3'h7;
    localparam logic [2:0] PS_A_OFF = 3'h1;
    localparam logic [2:0] PS_B_OFF = 3'h2;
    localparam logic [2:0] PS_AB_OFF = 3'h3;
    localparam int LAT_NORMAL = 14;
    localparam int LAT_LOW = 10;
    localparam int FRAC_W = 29;
    localparam int ACC_W = 44;
    localparam logic [10:0] OB_POS_CLIP = 11'h7ff;
    localparam logic [10:0] OB_NEG_CLIP = 11'h000;
    localparam logic [10:0] TC_POS_CLIP = 11'h3ff;
    localparam logic [10:0] TC_NEG_CLIP = 11'h400;
    localparam logic [10:0] SIGN_FLIP = 11'h400;
    // Log2 of the averaging span for each time-constant code
    localparam logic [4:0] TC_LOG2_0 = 5'd27;
    localparam logic [4:0] TC_LOG2_1 = 5'd26;
    localparam logic [4:0] TC_LOG2_2 = 5'd25;
    localparam logic [4:0] TC_LOG2_3 = 5'd24;
    localparam logic [4:0] TC_LOG2_4 = 5'd28;
    localparam logic [4:0] TC_LOG2_5 = 5'd29;
    localparam logic [4:0] TC_LOG2_DFLT = 5'd27;

    typedef struct packed {
        logic pos_over;
        logic neg_over;
        logic [10:0] code;
    } aof_sample_type;

    typedef enum logic [0:0] {
        AOF_HALF_HIGH = 1'b0,
        AOF_HALF_LOW = 1'b1
    } aof_half_type;
endpackage : aof_pkg

// >>> rtl/aof_top.sv
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module aof_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [10:0] chan_a_raw,
    input wire logic [10:0] chan_b_raw,
    input wire logic chan_a_pos_over,
    input wire logic chan_a_neg_over,
    input wire logic chan_b_pos_over,
    input wire logic chan_b_neg_over,
    input wire logic serial_sel_pin,
    input wire logic mode_pin_a,
    input wire logic mode_pin_b,
    input wire logic mode_pin_c,
    output logic sample_strobe,
    output logic [10:0] chan_a_bus,
    output logic chan_a_oe,
    output logic [10:0] chan_b_bus,
    output logic chan_b_oe,
    output logic fwd_clock,
    output logic [5:0] ddr_a_pair,
    output logic [5:0] ddr_b_pair,
    output logic fwd_clock_pos,
    output logic fwd_clock_neg,
    output logic ddr_oe,
    output logic [1:0] lvds_current_sel,
    output logic current_double,
    output logic [2:0] term_leg_en,
    output logic data_pin_drive_sel,
    output logic clock_pin_drive_sel
);
    //////////////////////////////////////////////////////////////////////////
    localparam int ACC_W_L = aof_pkg::ACC_W;
    logic [15:0] ctrl;
    logic [7:0] drive;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    aof_pkg::aof_half_type half;
    logic take;
    logic ddr_mode;
    logic twos_mode;
    logic mux_mode;
    logic [2:0] pstate;
    logic trim_active;
    logic [4:0] tc_log2;
    logic [31:0] rd_value;
    logic mapped;
    logic signed [ACC_W_L-1:0] acc [2];
    logic signed [12:0] est [2];
    aof_pkg::aof_sample_type in_smp [2];
    aof_pkg::aof_sample_type fix_smp [2];
    aof_pkg::aof_sample_type pipe_a [aof_pkg::LAT_NORMAL];
    aof_pkg::aof_sample_type pipe_b [aof_pkg::LAT_NORMAL];
    aof_pkg::aof_sample_type tap [2];
    logic [10:0] word [2];
    logic [10:0] next_word [2];

    //////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states; read data captured in the setup cycle
    assign pready = 1'b1;
    assign take = (half == aof_pkg::AOF_HALF_LOW);
    assign sample_strobe = take;

    always_comb begin
        mapped = 1'b1;
        rd_value = 32'h0000_0000;
        if (paddr == aof_pkg::OFF_CTRL) begin
            rd_value = {16'h0000, ctrl};
        end else if (paddr == aof_pkg::OFF_DRIVE) begin
            rd_value = {24'h00_0000, drive};
        end else if (paddr == aof_pkg::OFF_EST_A) begin
            rd_value = {{19{est[0][12]}}, est[0]};
        end else if (paddr == aof_pkg::OFF_EST_B) begin
            rd_value = {{19{est[1][12]}}, est[1]};
        end else if (paddr == aof_pkg::OFF_STATUS) begin
            rd_value = {25'h000_0000, trim_active, pstate, mux_mode, twos_mode, ddr_mode};
        end else begin
            mapped = 1'b0;
        end
    end

    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= rd_value;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= aof_pkg::CTRL_RESET;
            drive <= aof_pkg::DRIVE_RESET;
        end else if (psel && penable && pwrite) begin
            if (paddr == aof_pkg::OFF_CTRL) begin
                ctrl <= {1'b0, pwdata[14:12], 2'b00, pwdata[9:0]};
            end else if (paddr == aof_pkg::OFF_DRIVE) begin
                drive <= pwdata[7:0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Buffer settings reach the pad controls through one register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvds_current_sel <= aof_pkg::CUR_3P5MA;
            current_double <= 1'b0;
            term_leg_en <= 3'h0;
            data_pin_drive_sel <= 1'b0;
            clock_pin_drive_sel <= 1'b0;
        end else begin
            lvds_current_sel <= drive[aof_pkg::DRV_CUR_LSB +: 2];
            current_double <= drive[aof_pkg::DRV_DOUBLE];
            term_leg_en <= drive[aof_pkg::DRV_TERM_LSB +: 3];
            data_pin_drive_sel <= drive[aof_pkg::DRV_DATA_STR];
            clock_pin_drive_sel <= drive[aof_pkg::DRV_CLK_STR];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pins are asynchronous straps; two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
        end else begin
            pin_s1 <= {serial_sel_pin, mode_pin_a, mode_pin_b, mode_pin_c};
            pin_s2 <= pin_s1;
        end
    end

    always_comb begin
        if (ctrl[aof_pkg::CTL_PINS]) begin
            ddr_mode = pin_s2[3];
            twos_mode = pin_s2[3];
            pstate = pin_s2[2:0];
        end else begin
            ddr_mode = ctrl[aof_pkg::CTL_DDR];
            twos_mode = ctrl[aof_pkg::CTL_TWOS];
            pstate = ctrl[aof_pkg::CTL_PS_LSB +: 3];
        end
        mux_mode = (pstate == aof_pkg::PS_MUX) && !ddr_mode;
        trim_active = ctrl[aof_pkg::CTL_TRIM_EN] && !ctrl[aof_pkg::CTL_LOWLAT];
        case (ctrl[aof_pkg::CTL_TC_LSB +: 3])
            3'h0: tc_log2 = aof_pkg::TC_LOG2_0;
            3'h1: tc_log2 = aof_pkg::TC_LOG2_1;
            3'h2: tc_log2 = aof_pkg::TC_LOG2_2;
            3'h3: tc_log2 = aof_pkg::TC_LOG2_3;
            3'h4: tc_log2 = aof_pkg::TC_LOG2_4;
            3'h5: tc_log2 = aof_pkg::TC_LOG2_5;
            default: tc_log2 = aof_pkg::TC_LOG2_DFLT;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Sample period is two pclk cycles: high half then low half
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half <= aof_pkg::AOF_HALF_HIGH;
        end else begin
            case (half)
                aof_pkg::AOF_HALF_HIGH: half <= aof_pkg::AOF_HALF_LOW;
                default: half <= aof_pkg::AOF_HALF_HIGH;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Offset loop per channel; estimate is the integer part of the accumulator
    assign in_smp[0] = '{pos_over: chan_a_pos_over, neg_over: chan_a_neg_over, code: chan_a_raw};
    assign in_smp[1] = '{pos_over: chan_b_pos_over, neg_over: chan_b_neg_over, code: chan_b_raw};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_trim
            logic signed [13:0] diff;
            logic signed [10:0] sat;
            logic signed [ACC_W_L-1:0] step;
            logic [4:0] shamt;
            assign est[ch] = acc[ch][aof_pkg::FRAC_W +: 13];
            always_comb begin
                // Raw code is offset binary; inverting the top bit centres it
                diff = $signed({{3{~in_smp[ch].code[10]}}, ~in_smp[ch].code[10],
                    in_smp[ch].code[9:0]}) - $signed({est[ch][12], est[ch]});
                if (diff > 14'sd1023) begin
                    sat = 11'sd1023;
                end else if (diff < -14'sd1024) begin
                    sat = 11'sh400;
                end else begin
                    sat = diff[10:0];
                end
                shamt = 5'(aof_pkg::FRAC_W) - tc_log2;
                step = $signed({{(ACC_W_L-14){diff[13]}}, diff}) <<< shamt;
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    acc[ch] <= '0;
                end else if (!trim_active) begin
                    acc[ch] <= '0;
                end else if (take && !ctrl[aof_pkg::CTL_FREEZE]) begin
                    acc[ch] <= acc[ch] + step;
                end
            end
            always_comb begin
                fix_smp[ch] = in_smp[ch];
                if (trim_active) begin
                    fix_smp[ch].code = sat;
                end else begin
                    fix_smp[ch].code = in_smp[ch].code ^ aof_pkg::SIGN_FLIP;
                end
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Delay line holds signed codes; format applied at the output tap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < aof_pkg::LAT_NORMAL; i++) begin
                pipe_a[i] <= '0;
                pipe_b[i] <= '0;
            end
        end else if (take) begin
            pipe_a[0] <= fix_smp[0];
            pipe_b[0] <= fix_smp[1];
            for (int i = 1; i < aof_pkg::LAT_NORMAL; i++) begin
                pipe_a[i] <= pipe_a[i-1];
                pipe_b[i] <= pipe_b[i-1];
            end
        end
    end

    always_comb begin
        if (ctrl[aof_pkg::CTL_LOWLAT]) begin
            tap[0] = pipe_a[aof_pkg::LAT_LOW-1];
            tap[1] = pipe_b[aof_pkg::LAT_LOW-1];
        end else begin
            tap[0] = pipe_a[aof_pkg::LAT_NORMAL-1];
            tap[1] = pipe_b[aof_pkg::LAT_NORMAL-1];
        end
        for (int c = 0; c < 2; c++) begin
            next_word[c] = word[c];
            if (take) begin
                if (tap[c].pos_over) begin
                    next_word[c] = twos_mode ? aof_pkg::TC_POS_CLIP : aof_pkg::OB_POS_CLIP;
                end else if (tap[c].neg_over) begin
                    next_word[c] = twos_mode ? aof_pkg::TC_NEG_CLIP : aof_pkg::OB_NEG_CLIP;
                end else if (twos_mode) begin
                    next_word[c] = tap[c].code;
                end else begin
                    next_word[c] = tap[c].code ^ aof_pkg::SIGN_FLIP;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word[0] <= 11'h000;
            word[1] <= 11'h000;
        end else begin
            word[0] <= next_word[0];
            word[1] <= next_word[1];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pins are registered from next_word so data and clock leave together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_clock <= 1'b0;
            fwd_clock_pos <= 1'b0;
            fwd_clock_neg <= 1'b1;
            ddr_a_pair <= 6'h00;
            ddr_b_pair <= 6'h00;
            chan_a_bus <= 11'h000;
            chan_b_bus <= 11'h000;
        end else begin
            fwd_clock <= take;
            fwd_clock_pos <= take;
            fwd_clock_neg <= !take;
            for (int p = 0; p < aof_pkg::PAIR_N; p++) begin
                if (take) begin
                    // Top pair has no odd partner above bit 10
                    ddr_a_pair[p] <= (p < 5) ? next_word[0][(2*p+1) % aof_pkg::DATA_W]
                        : 1'b0;
                    ddr_b_pair[p] <= (p < 5) ? next_word[1][(2*p+1) % aof_pkg::DATA_W]
                        : 1'b0;
                end else begin
                    ddr_a_pair[p] <= word[0][2*p];
                    ddr_b_pair[p] <= word[1][2*p];
                end
            end
            if (take) begin
                chan_a_bus <= next_word[0];
                chan_b_bus <= mux_mode ? next_word[0] : next_word[1];
            end else begin
                chan_b_bus <= mux_mode ? word[1] : word[1];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ddr_oe <= 1'b0;
            chan_a_oe <= 1'b0;
            chan_b_oe <= 1'b0;
        end else begin
            ddr_oe <= ddr_mode;
            chan_a_oe <= !ddr_mode && !mux_mode && (pstate != aof_pkg::PS_A_OFF)
                && (pstate != aof_pkg::PS_AB_OFF);
            chan_b_oe <= !ddr_mode && (pstate != aof_pkg::PS_B_OFF)
                && (pstate != aof_pkg::PS_AB_OFF);
        end
    end
endmodule : aof_top
`default_nettype wire

// >>> test/aof_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module aof_top_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic sample_strobe,
    input wire logic [10:0] chan_a_bus,
    input wire logic chan_a_oe,
    input wire logic fwd_clock,
    input wire logic [5:0] ddr_a_pair,
    input wire logic [5:0] ddr_b_pair,
    input wire logic fwd_clock_pos,
    input wire logic fwd_clock_neg,
    input wire logic ddr_oe,
    input wire logic [1:0] lvds_current_sel,
    input wire logic current_double,
    input wire logic [2:0] term_leg_en,
    input wire logic data_pin_drive_sel,
    input wire logic clock_pin_drive_sel
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic access;
    logic mapped;
    logic [7:0] drive_word;
    assign access = psel && penable;
    assign mapped = paddr inside {aof_pkg::OFF_CTRL, aof_pkg::OFF_DRIVE, aof_pkg::OFF_EST_A,
        aof_pkg::OFF_EST_B, aof_pkg::OFF_STATUS};
    assign drive_word = {clock_pin_drive_sel, data_pin_drive_sel, term_leg_en, current_double,
        lvds_current_sel};
    //////////////////////////////////////////////////////////
    err_map_a:
    assert property (access |-> pslverr == !mapped) else $error("bus error flag wrong");
    err_zero_a:
    assert property (access && !pwrite && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    // Two edges allowed: the pins may sit one stage behind the register
    drive_copy_a:
    assert property (access && pwrite && paddr == aof_pkg::OFF_DRIVE |-> ##2
        drive_word == 8'($past(pwdata, 2))) else $error("drive pins do not follow write");
    strobe_alt_a:
    assert property (sample_strobe |=> !sample_strobe ##1 sample_strobe)
        else $error("strobe does not alternate");
    clk_half_a:
    assert property (sample_strobe |-> !fwd_clock && !fwd_clock_pos)
        else $error("forwarded clock high in strobe half");
    ddr_pair_a:
    assert property (ddr_oe |-> fwd_clock_neg != fwd_clock_pos)
        else $error("clock pair not complementary");
    ddr_top_a:
    assert property (ddr_oe && fwd_clock_pos |-> !ddr_a_pair[5] && !ddr_b_pair[5])
        else $error("unused odd bit driven");
    cmos_hold_a:
    assert property (!ddr_oe && chan_a_oe && sample_strobe |-> $stable(chan_a_bus))
        else $error("parallel data changed mid sample");
endmodule : aof_top_asserts
`default_nettype wire

// >>> test/aof_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
module aof_rx_model (
    input wire logic pclk,
    input wire logic fwd_clock_pos,
    input wire logic [5:0] ddr_a_pair,
    input wire logic [5:0] ddr_b_pair,
    output logic [10:0] word_a,
    output logic [10:0] word_b
);
    logic [5:0] odd_a;
    logic [5:0] odd_b;
    function automatic logic [10:0] merge(input logic [5:0] odd, input logic [5:0] even);
        for (int p = 0; p < 6; p++) begin
            merge[2 * p] = even[p];
            if (p < 5) merge[2 * p + 1] = odd[p];
        end
    endfunction : merge
    // Mid-cycle sampling stands in for capture on both forwarded clock edges
    always @(negedge pclk) begin
        if (fwd_clock_pos) begin
            odd_a <= ddr_a_pair;
            odd_b <= ddr_b_pair;
        end else begin
            word_a <= merge(odd_a, ddr_a_pair);
            word_b <= merge(odd_b, ddr_b_pair);
        end
    end
endmodule : aof_rx_model
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, drv;
    logic [31:0] pwdata, prdata, rdat;
    logic [10:0] chan_a_raw, chan_b_raw, chan_a_bus, chan_b_bus, word_a, word_b;
    logic chan_a_pos_over, chan_a_neg_over, chan_b_pos_over, chan_b_neg_over;
    logic serial_sel_pin, mode_pin_a, mode_pin_b, mode_pin_c, sample_strobe, chan_a_oe;
    logic chan_b_oe, fwd_clock, fwd_clock_pos, fwd_clock_neg, ddr_oe, current_double;
    logic data_pin_drive_sel, clock_pin_drive_sel;
    logic [5:0] ddr_a_pair, ddr_b_pair;
    logic [1:0] lvds_current_sel;
    logic [2:0] term_leg_en;
    logic [7:0] drv_tab [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h10, 8'h20,
        8'h38, 8'h40, 8'h80};
    int bad_count, num_checks, lat;

    aof_top aof_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .chan_a_raw, .chan_b_raw, .chan_a_pos_over, .chan_a_neg_over,
        .chan_b_pos_over, .chan_b_neg_over, .serial_sel_pin, .mode_pin_a, .mode_pin_b,
        .mode_pin_c, .sample_strobe, .chan_a_bus, .chan_a_oe, .chan_b_bus, .chan_b_oe,
        .fwd_clock, .ddr_a_pair, .ddr_b_pair, .fwd_clock_pos, .fwd_clock_neg, .ddr_oe,
        .lvds_current_sel, .current_double, .term_leg_en, .data_pin_drive_sel,
        .clock_pin_drive_sel);
    aof_rx_model aof_rx_model_i (.pclk, .fwd_clock_pos, .ddr_a_pair, .ddr_b_pair, .word_a,
        .word_b);
    assign drv = {clock_pin_drive_sel, data_pin_drive_sel, term_leg_en, current_double,
        lvds_current_sel};

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    //////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge pclk);
    endtask : cyc
    task automatic stat(input logic [31:0] exp);
        cyc(6);
        apb(1'b0, aof_pkg::OFF_STATUS, '0);
        chk("status", exp, rdat);
    endtask : stat
    task automatic setin(input logic [10:0] a, input logic [10:0] b, input logic [3:0] f);
        @(posedge pclk);
        chan_a_raw <= a;
        chan_b_raw <= b;
        {chan_a_pos_over, chan_a_neg_over, chan_b_pos_over, chan_b_neg_over} <= f;
    endtask : setin
    // Counts edges from the take edge of a new code until it shows on bus A
    task automatic measure(input logic [10:0] v);
        cyc(1);
        while (sample_strobe !== 1'b0) cyc(1);
        @(posedge pclk);
        chan_a_raw <= v;
        @(posedge pclk);
        lat = 0;
        while (chan_a_bus !== v && lat < 60) begin
            @(posedge pclk);
            lat++;
            cyc(1);
        end
    endtask : measure
    function automatic logic [10:0] code(input int k, input int t, input logic [10:0] r);
        if (k == 1) return (t == 1) ? 11'h3ff : 11'h7ff;
        if (k == 2) return (t == 1) ? 11'h400 : 11'h000;
        return r ^ {t == 1, 10'h000};
    endfunction : code
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    //////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {chan_a_raw, chan_b_raw, chan_a_pos_over, chan_a_neg_over} = '0;
        {chan_b_pos_over, chan_b_neg_over, serial_sel_pin, mode_pin_a} = '0;
        {mode_pin_b, mode_pin_c, bad_count, num_checks} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, aof_pkg::OFF_CTRL, '0);
        chk("ctrl reset", 32'(aof_pkg::CTRL_RESET), rdat);
        apb(1'b0, aof_pkg::OFF_DRIVE, '0);
        chk("drive reset", 32'(aof_pkg::DRIVE_RESET), rdat);
        chk("current reset", 32'(aof_pkg::CUR_3P5MA), 32'(lvds_current_sel));
        foreach (drv_tab[i]) begin
            apb(1'b1, aof_pkg::OFF_DRIVE, 32'(drv_tab[i]));
            cyc(2);
            chk("drive pins", 32'(drv_tab[i]), 32'(drv));
        end
        apb(1'b0, 8'h14, '0);
        chk("unmapped error", 1'b1, 32'(err));
        chk("unmapped data", '0, rdat);
        $display("test registers finished");
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, aof_pkg::OFF_CTRL, 32'(i / 3) << aof_pkg::CTL_TWOS);
            setin(11'h123, 11'h5a5, {i % 3 == 1, i % 3 == 2, i % 3 == 2, i % 3 == 1});
            cyc(40);
            chk("bus a", 32'(code(i % 3, i / 3, 11'h123)), 32'(chan_a_bus));
            chk("bus b", 32'(code((3 - i % 3) % 3, i / 3, 11'h5a5)), 32'(chan_b_bus));
        end
        $display("test format finished");
        apb(1'b1, aof_pkg::OFF_CTRL, 32'h0000_0001);
        setin(11'h6b5, 11'h29a, 4'h0);
        cyc(40);
        chk("ddr enable", 1'b1, 32'(ddr_oe));
        chk("ddr word a", 32'h0000_06b5, 32'(word_a));
        chk("ddr word b", 32'h0000_029a, 32'(word_b));
        $display("test ddr finished");
        apb(1'b1, aof_pkg::OFF_CTRL, '0);
        cyc(40);
        measure(11'h0f0);
        chk("normal latency", 32'(2 * 14), 32'(lat));
        apb(1'b1, aof_pkg::OFF_CTRL, 32'h0000_0104);
        cyc(40);
        measure(11'h30f);
        chk("low latency", 32'(2 * 10), 32'(lat));
        stat(32'h0000_0000);
        $display("test latency finished");
        // Sample rate is half of pclk, well inside the shared-bus limit
        apb(1'b1, aof_pkg::OFF_CTRL, 32'h0000_0070);
        setin(11'h111, 11'h622, 4'h0);
        cyc(40);
        if (fwd_clock !== 1'b1) cyc(1);
        chk("mux first half", 32'h0000_0111, 32'(chan_b_bus));
        chk("mux float a", 1'b0, 32'(chan_a_oe));
        cyc(1);
        chk("mux second half", 32'h0000_0622, 32'(chan_b_bus));
        stat(32'h0000_003c);
        apb(1'b1, aof_pkg::OFF_CTRL, 32'h0000_0071);
        stat(32'h0000_0039);
        apb(1'b1, aof_pkg::OFF_CTRL, 32'h0000_0008);
        @(posedge pclk);
        {mode_pin_a, mode_pin_b, mode_pin_c} <= 3'h7;
        stat(32'h0000_003c);
        @(posedge pclk);
        serial_sel_pin <= 1'b1;
        stat(32'h0000_003b);
        @(posedge pclk);
        {mode_pin_a, mode_pin_b, mode_pin_c, serial_sel_pin} <= 4'h0;
        $display("test modes finished");
        for (int t = 0; t < 8; t++) begin
            apb(1'b1, aof_pkg::OFF_CTRL, 32'h0000_0100 | (32'(t) << 12));
            apb(1'b0, aof_pkg::OFF_CTRL, '0);
            chk("time const", 32'h0000_0100 | (32'(t) << 12), rdat);
            stat(32'h0000_0040);
        end
        // Disable first so the estimate restarts from zero before freezing
        apb(1'b1, aof_pkg::OFF_CTRL, '0);
        apb(1'b1, aof_pkg::OFF_CTRL, 32'h0000_0300);
        cyc(20);
        apb(1'b0, aof_pkg::OFF_EST_A, '0);
        chk("frozen estimate", '0, rdat);
        $display("test trim finished");
        print_verdict();
    end
    initial begin
        repeat (8000) @(posedge pclk);
        bad_count++;
        print_verdict();
    end
endmodule : testbench
bind aof_top aof_top_asserts aof_top_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pslverr, .sample_strobe, .chan_a_bus, .chan_a_oe, .fwd_clock,
    .ddr_a_pair, .ddr_b_pair, .fwd_clock_pos, .fwd_clock_neg, .ddr_oe, .lvds_current_sel,
    .current_double, .term_leg_en, .data_pin_drive_sel, .clock_pin_drive_sel);
`default_nettype wire
